/* File: hw/can_filter_pkg.sv */
// Constants, field layout and carrier types of the CAN acceptance filter
// and FIFO pointer block.
// Assumes a 32-bit register port with byte addresses and one clock.
//
// Contract
// - Each filter has a one-bit enable; set takes part in acceptance.
// - A two-bit mask selector picks acceptance mask 0 to 3 by its code.
// - A five-bit FIFO selector names the FIFO, 0 to 31, for matches.
// - Filter 5 sits in bits 15, 14-13, 12-8 and filter 4 in 7, 6-5, 4-0.
// - Mask and FIFO selector writes land only while the enable is zero.
// - A transmit FIFO's user address is the head, where software writes.
// - A receive FIFO's user address is the tail, where software reads.
// - The two low bits of the user address always read as zero.
// - The message index is five read-only bits, reset zero, upper zero.
// - A transmit FIFO's index names the message to be sent next.
// - A receive FIFO's index names the slot for the next reception.

`default_nettype none

package can_filter_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam int          ADDR_W          = 10;
    localparam int          DATA_W          = 32;
    localparam logic [9:0]  OFS_CONTROL     = 10'h000;
    localparam logic [9:0]  OFS_FLTCON1     = 10'h004;
    localparam logic [9:0]  OFS_DIRECTION   = 10'h008;
    localparam logic [9:0]  OFS_MSG_BASE    = 10'h00C;
    localparam logic [9:0]  OFS_MASK0       = 10'h010;
    localparam logic [9:0]  OFS_MASK1       = 10'h014;
    localparam logic [9:0]  OFS_MASK2       = 10'h018;
    localparam logic [9:0]  OFS_MASK3       = 10'h01C;
    localparam logic [9:0]  OFS_FILTER4_ID  = 10'h020;
    localparam logic [9:0]  OFS_FILTER5_ID  = 10'h024;
    localparam logic [9:0]  OFS_ADVANCE     = 10'h028;
    localparam logic [2:0]  UA_REGION       = 3'h2;
    localparam logic [2:0]  CI_REGION       = 3'h3;

    // ==========================================================
    // Field positions
    localparam int          CTRL_CFG_BIT    = 0;
    localparam int          F5_EN_BIT       = 15;
    localparam int          F5_MSEL_LSB     = 13;
    localparam int          F5_FSEL_LSB     = 8;
    localparam int          F4_EN_BIT       = 7;
    localparam int          F4_MSEL_LSB     = 5;
    localparam int          F4_FSEL_LSB     = 0;

    // ==========================================================
    // Reset values and sizes
    localparam logic [31:0] CONTROL_RST     = 32'h0000_0001;
    localparam logic [31:0] ZERO_RST        = 32'h0000_0000;
    localparam logic [4:0]  INDEX_RST       = 5'h00;
    localparam logic [31:0] ALIGN_MASK      = 32'hFFFF_FFFC;
    localparam int          NUM_FIFO        = 32;
    localparam int          NUM_MASK        = 4;
    localparam int          ID_W            = 29;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic            valid;
        logic [ID_W-1:0] id;
    } rx_frame_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] fifo;
    } tx_done_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  fifo;
        logic [31:0] addr;
    } store_req_t;

    typedef struct packed {
        logic       en;
        logic [1:0] msel;
        logic [4:0] fsel;
    } filter_ctl_t;

endpackage

`default_nettype wire

/* File: hw/can_filter_fifo.sv */
// Acceptance filters 4 and 5 with their FIFO routing, plus the user
// address and message index pointers of all 32 FIFOs.
// Assumes the frame and transmit-done carriers come from logic on
// ref_clk, and software uses the plain register port on the same clock.

`timescale 1ns/10ps
`default_nettype none

module can_filter_fifo
    import can_filter_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire rx_frame_t         rx_frame,
    input  wire tx_done_t          tx_done,
    output store_req_t             store_req,
    output logic                   config_mode
);

    // ==========================================================
    // Register state
    logic                config_r;
    logic                config_nxt;
    filter_ctl_t         flt4_r;
    filter_ctl_t         flt4_nxt;
    filter_ctl_t         flt5_r;
    filter_ctl_t         flt5_nxt;
    logic [NUM_FIFO-1:0] tx_dir_r;
    logic [NUM_FIFO-1:0] tx_dir_nxt;
    logic [31:0]         msg_base_r;
    logic [31:0]         msg_base_nxt;
    logic [ID_W-1:0]     mask_r     [NUM_MASK];
    logic [ID_W-1:0]     mask_nxt   [NUM_MASK];
    logic [ID_W-1:0]     flt4_id_r;
    logic [ID_W-1:0]     flt4_id_nxt;
    logic [ID_W-1:0]     flt5_id_r;
    logic [ID_W-1:0]     flt5_id_nxt;

    // Software-side and bus-side slot index of each FIFO
    logic [4:0]          user_idx_r [NUM_FIFO];
    logic [4:0]          user_idx_nxt [NUM_FIFO];
    logic [4:0]          can_idx_r  [NUM_FIFO];
    logic [4:0]          can_idx_nxt [NUM_FIFO];

    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    store_req_t          store_r;
    store_req_t          store_nxt;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] slot_addr(
        input logic [31:0] base,
        input logic [4:0]  fifo,
        input logic [4:0]  idx
    );
        logic [31:0] offs;
        offs = {18'h0, fifo, idx, 4'h0};
        // Low bits forced clear so reported addresses stay aligned
        return (base + offs) & ALIGN_MASK;
    endfunction

    // ==========================================================
    // Acceptance
    logic [ID_W-1:0] sel_mask4;
    logic [ID_W-1:0] sel_mask5;
    logic            hit4;
    logic            hit5;
    logic            accept;
    logic [4:0]      dest_fifo;

    always_comb begin
        sel_mask4 = mask_r[flt4_r.msel];
        sel_mask5 = mask_r[flt5_r.msel];
    end

    can_filter_match i_can_filter_match4 (
        .ctl (flt4_r),
        .fid (flt4_id_r),
        .mask(sel_mask4),
        .id  (rx_frame.id),
        .hit (hit4)
    );

    can_filter_match i_can_filter_match5 (
        .ctl (flt5_r),
        .fid (flt5_id_r),
        .mask(sel_mask5),
        .id  (rx_frame.id),
        .hit (hit5)
    );

    always_comb begin
        // Lower filter number wins when both match
        dest_fifo = hit4 ? flt4_r.fsel : flt5_r.fsel;
        // Frames are dropped in Configuration mode and when the chosen
        // FIFO is set up to transmit
        accept = rx_frame.valid && !config_r && (hit4 || hit5)
                 && !tx_dir_r[dest_fifo];
    end

    // ==========================================================
    // Register writes
    always_comb begin
        config_nxt   = config_r;
        flt4_nxt     = flt4_r;
        flt5_nxt     = flt5_r;
        tx_dir_nxt   = tx_dir_r;
        msg_base_nxt = msg_base_r;
        flt4_id_nxt  = flt4_id_r;
        flt5_id_nxt  = flt5_id_r;
        for (int m = 0; m < NUM_MASK; m++) begin
            mask_nxt[m] = mask_r[m];
        end
        if (reg_wr) begin
            case (reg_addr)
                OFS_CONTROL: begin
                    config_nxt = reg_wdata[CTRL_CFG_BIT];
                end
                OFS_FLTCON1: begin
                    flt5_nxt.en = reg_wdata[F5_EN_BIT];
                    flt4_nxt.en = reg_wdata[F4_EN_BIT];
                    if (!flt5_r.en) begin
                        flt5_nxt.msel =
                            reg_wdata[F5_MSEL_LSB +: 2];
                        flt5_nxt.fsel =
                            reg_wdata[F5_FSEL_LSB +: 5];
                    end
                    if (!flt4_r.en) begin
                        flt4_nxt.msel =
                            reg_wdata[F4_MSEL_LSB +: 2];
                        flt4_nxt.fsel =
                            reg_wdata[F4_FSEL_LSB +: 5];
                    end
                end
                OFS_DIRECTION: begin
                    tx_dir_nxt = reg_wdata;
                end
                OFS_MSG_BASE: begin
                    msg_base_nxt = reg_wdata & ALIGN_MASK;
                end
                OFS_MASK0: begin
                    mask_nxt[0] = reg_wdata[ID_W-1:0];
                end
                OFS_MASK1: begin
                    mask_nxt[1] = reg_wdata[ID_W-1:0];
                end
                OFS_MASK2: begin
                    mask_nxt[2] = reg_wdata[ID_W-1:0];
                end
                OFS_MASK3: begin
                    mask_nxt[3] = reg_wdata[ID_W-1:0];
                end
                OFS_FILTER4_ID: begin
                    flt4_id_nxt = reg_wdata[ID_W-1:0];
                end
                OFS_FILTER5_ID: begin
                    flt5_id_nxt = reg_wdata[ID_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            config_r   <= CONTROL_RST[CTRL_CFG_BIT];
            flt4_r     <= '0;
            flt5_r     <= '0;
            tx_dir_r   <= ZERO_RST;
            msg_base_r <= ZERO_RST;
            flt4_id_r  <= '0;
            flt5_id_r  <= '0;
            for (int m = 0; m < NUM_MASK; m++) begin
                mask_r[m] <= '0;
            end
        end else begin
            config_r   <= config_nxt;
            flt4_r     <= flt4_nxt;
            flt5_r     <= flt5_nxt;
            tx_dir_r   <= tx_dir_nxt;
            msg_base_r <= msg_base_nxt;
            flt4_id_r  <= flt4_id_nxt;
            flt5_id_r  <= flt5_id_nxt;
            for (int m = 0; m < NUM_MASK; m++) begin
                mask_r[m] <= mask_nxt[m];
            end
        end
    end

    // ==========================================================
    // FIFO pointers
    // Software advances its side by writing a FIFO number; the bus side
    // moves on a stored frame or a finished transmission. Each array has
    // one mover per FIFO direction, so no event can be lost to another.
    always_comb begin
        for (int n = 0; n < NUM_FIFO; n++) begin
            user_idx_nxt[n] = user_idx_r[n];
            can_idx_nxt[n]  = can_idx_r[n];
        end
        store_nxt = '0;
        if (config_r) begin
            // Pointers restart while the module is being configured
            for (int n = 0; n < NUM_FIFO; n++) begin
                user_idx_nxt[n] = INDEX_RST;
                can_idx_nxt[n]  = INDEX_RST;
            end
        end else begin
            if (reg_wr && reg_addr == OFS_ADVANCE) begin
                // Head moves for transmit, tail for receive
                user_idx_nxt[reg_wdata[4:0]] =
                    user_idx_r[reg_wdata[4:0]] + 5'h01;
            end
            if (accept) begin
                store_nxt.valid = 1'b1;
                store_nxt.fifo  = dest_fifo;
                store_nxt.addr  = slot_addr(msg_base_r, dest_fifo,
                                            can_idx_r[dest_fifo]);
                can_idx_nxt[dest_fifo] =
                    can_idx_r[dest_fifo] + 5'h01;
            end
            if (tx_done.valid && tx_dir_r[tx_done.fifo]) begin
                can_idx_nxt[tx_done.fifo] =
                    can_idx_r[tx_done.fifo] + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int n = 0; n < NUM_FIFO; n++) begin
                user_idx_r[n] <= INDEX_RST;
                can_idx_r[n]  <= INDEX_RST;
            end
            store_r <= '0;
        end else begin
            for (int n = 0; n < NUM_FIFO; n++) begin
                user_idx_r[n] <= user_idx_nxt[n];
                can_idx_r[n]  <= can_idx_nxt[n];
            end
            store_r <= store_nxt;
        end
    end

    // ==========================================================
    // Register reads
    // The user address is computed from live pointers; in Configuration
    // mode they are being cleared, so the value there is not meaningful.
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            if (reg_addr[9:7] == UA_REGION) begin
                rdata_nxt = slot_addr(msg_base_r, reg_addr[6:2],
                    user_idx_r[reg_addr[6:2]]);
            end else if (reg_addr[9:7] == CI_REGION) begin
                rdata_nxt = {27'h0, can_idx_r[reg_addr[6:2]]};
            end else begin
                case (reg_addr)
                    OFS_CONTROL: begin
                        rdata_nxt[CTRL_CFG_BIT] = config_r;
                    end
                    OFS_FLTCON1: begin
                        rdata_nxt[F5_EN_BIT]        = flt5_r.en;
                        rdata_nxt[F5_MSEL_LSB +: 2] = flt5_r.msel;
                        rdata_nxt[F5_FSEL_LSB +: 5] = flt5_r.fsel;
                        rdata_nxt[F4_EN_BIT]        = flt4_r.en;
                        rdata_nxt[F4_MSEL_LSB +: 2] = flt4_r.msel;
                        rdata_nxt[F4_FSEL_LSB +: 5] = flt4_r.fsel;
                    end
                    OFS_DIRECTION: begin
                        rdata_nxt = tx_dir_r;
                    end
                    OFS_MSG_BASE: begin
                        rdata_nxt = msg_base_r;
                    end
                    OFS_MASK0: begin
                        rdata_nxt[ID_W-1:0] = mask_r[0];
                    end
                    OFS_MASK1: begin
                        rdata_nxt[ID_W-1:0] = mask_r[1];
                    end
                    OFS_MASK2: begin
                        rdata_nxt[ID_W-1:0] = mask_r[2];
                    end
                    OFS_MASK3: begin
                        rdata_nxt[ID_W-1:0] = mask_r[3];
                    end
                    OFS_FILTER4_ID: begin
                        rdata_nxt[ID_W-1:0] = flt4_id_r;
                    end
                    OFS_FILTER5_ID: begin
                        rdata_nxt[ID_W-1:0] = flt5_id_r;
                    end
                    default: begin
                        rdata_nxt = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= ZERO_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata   = rdata_r;
    assign store_req   = store_r;
    assign config_mode = config_r;

endmodule

// ==========================================================
// One acceptance filter. A set mask bit means that id bit must equal
// the filter's own bit; a cleared enable never matches, whatever the id.
module can_filter_match
    import can_filter_pkg::*;
#(
    parameter int WID = ID_W
)
(
    input  wire filter_ctl_t    ctl,
    input  wire logic [WID-1:0] fid,
    input  wire logic [WID-1:0] mask,
    input  wire logic [WID-1:0] id,
    output logic                hit
);

    logic [WID-1:0] diff;

    always_comb begin
        diff = (id ^ fid) & mask;
        hit  = ctl.en && (diff == '0);
    end

endmodule

`default_nettype wire

/* File: bench/can_filter_fifo_monitor.sv */
// Concurrent checks on the ports of the filter and FIFO pointer block.
// Assumes the register map and timing given in the package constants.
`timescale 1ns/10ps
`default_nettype none
module can_filter_fifo_monitor
    import can_filter_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire rx_frame_t         rx_frame,
    input wire tx_done_t          tx_done,
    input wire store_req_t        store_req,
    input wire logic              config_mode
);
    // ==========================================================
    // Shadow of filter_control_one
    // Fields of an enabled filter stay frozen, so a write cannot reroute
    logic [15:0] fc_r;
    logic [15:0] fc_nxt;
    always_comb begin
        fc_nxt = fc_r;
        if (reg_wr && reg_addr == OFS_FLTCON1) begin
            fc_nxt[15] = reg_wdata[15];
            fc_nxt[7]  = reg_wdata[7];
            if (!fc_r[15]) fc_nxt[14:8] = reg_wdata[14:8];
            if (!fc_r[7]) fc_nxt[6:0] = reg_wdata[6:0];
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) fc_r <= 16'h0000;
        else fc_r <= fc_nxt;
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [2:0] rg);
        reg_rd && reg_addr[9:7] == rg;
    endsequence
    sequence s_cfg_rd;
        config_mode ##1 (reg_rd && config_mode && reg_addr[9:7] == CI_REGION);
    endsequence
    sequence s_idle_hit;
        rx_frame.valid && !config_mode && !fc_r[7] && !fc_r[15];
    endsequence
    property p_fltcon_read;
        reg_rd && reg_addr == OFS_FLTCON1 |=> reg_rdata[15:0] == fc_r;
    endproperty
    property p_ua_low;
        s_rd(UA_REGION) |=> reg_rdata[1:0] == 2'h0;
    endproperty
    property p_ci_high;
        s_rd(CI_REGION) |=> reg_rdata[31:5] == 27'h0;
    endproperty
    property p_ci_cfg;
        s_cfg_rd |=> reg_rdata == 32'h0;
    endproperty
    property p_store_cause;
        store_req.valid |-> $past(rx_frame.valid && !config_mode);
    endproperty
    property p_store_fifo;
        store_req.valid |-> ($past(fc_r[7]) &&
            store_req.fifo == $past(fc_r[4:0])) || ($past(fc_r[15]) &&
            store_req.fifo == $past(fc_r[12:8]));
    endproperty
    property p_store_align;
        store_req.valid |-> store_req.addr[1:0] == 2'h0;
    endproperty
    property p_store_pulse;
        store_req.valid && !rx_frame.valid |=> !store_req.valid;
    endproperty
    property p_disabled_drop;
        s_idle_hit |=> !store_req.valid;
    endproperty
    a_fltcon_read: assert property (p_fltcon_read)
        else $error("filter control readback differs from shadow");
    a_ua_low: assert property (p_ua_low)
        else $error("user address low bits not zero");
    a_ci_high: assert property (p_ci_high)
        else $error("message index upper bits not zero");
    a_ci_cfg: assert property (p_ci_cfg)
        else $error("message index not cleared in configuration");
    a_store_cause: assert property (p_store_cause)
        else $error("store without an accepted frame");
    a_store_fifo: assert property (p_store_fifo)
        else $error("store to a FIFO no enabled filter selects");
    a_store_align: assert property (p_store_align)
        else $error("store address not aligned");
    a_store_pulse: assert property (p_store_pulse)
        else $error("store request longer than one cycle");
    a_disabled_drop: assert property (p_disabled_drop)
        else $error("frame stored with both filters disabled");
endmodule

bind can_filter_fifo can_filter_fifo_monitor i_can_filter_fifo_monitor (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_frame(rx_frame), .tx_done(tx_done),
    .store_req(store_req), .config_mode(config_mode));
`default_nettype wire

/* File: bench/can_node_model.sv */
// Far-side model: other bus nodes handing frames and finished sends in.
// Assumes the bench commands each pulse one cycle ahead on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module can_node_model
    import can_filter_pkg::*;
(
    input  wire logic            ref_clk,
    input  wire logic            send_rx,
    input  wire logic [ID_W-1:0] rx_id,
    input  wire logic            send_tx,
    input  wire logic [4:0]      tx_fifo,
    output var  rx_frame_t       rx_frame,
    output var  tx_done_t        tx_done
);
    // ==========================================================
    // Pulses
    // Between pulses the payload toggles so a stale value never matches
    initial begin
        rx_frame = '0;
        tx_done  = '0;
    end
    always @(posedge ref_clk) begin
        rx_frame.valid <= send_rx;
        rx_frame.id    <= send_rx ? rx_id : ~rx_frame.id;
        tx_done.valid  <= send_tx;
        tx_done.fifo   <= send_tx ? tx_fifo : ~tx_done.fifo;
    end
endmodule
`default_nettype wire

/* File: bench/can_filter_fifo_routing_tb_top.sv */
// Self-checking bench for filter routing and the FIFO pointers.
// Assumes the package offsets and the timing of the register port.
`timescale 1ns/10ps
`default_nettype none
module can_filter_fifo_routing_tb_top
    import can_filter_pkg::*;
;
    logic              ref_clk, resetn, reg_wr, reg_rd, send_rx, send_tx;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, base;
    logic [ID_W-1:0]   rx_id, id;
    logic [4:0]        tx_fifo, f, ci_exp[NUM_FIFO];
    rx_frame_t         rx_frame;
    tx_done_t          tx_done;
    store_req_t        store_req;
    logic              config_mode;
    integer            n_fail, n_checks, seed, cyc, k;

    can_filter_fifo i_can_filter_fifo (
        .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_frame(rx_frame), .tx_done(tx_done),
        .store_req(store_req), .config_mode(config_mode));
    can_node_model i_can_node_model (
        .ref_clk(ref_clk), .send_rx(send_rx), .rx_id(rx_id),
        .send_tx(send_tx), .tx_fifo(tx_fifo), .rx_frame(rx_frame),
        .tx_done(tx_done));

    // ==========================================================
    // Clock, timeout and helpers
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    function automatic logic [31:0] ua(input logic [4:0] fi,
                                       input logic [4:0] ix);
        return (base + {18'h0, fi, ix, 4'h0}) & ALIGN_MASK;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Two writes: fields of an enabled filter would be ignored otherwise
    task automatic set_flt(input logic [7:0] f4, input logic [7:0] f5);
        wr(OFS_FLTCON1, 32'h0);
        wr(OFS_FLTCON1, {16'h0, f5, f4});
        rd(OFS_FLTCON1, {16'h0, f5, f4});
    endtask
    task automatic frame(input logic [ID_W-1:0] fid, input logic hit,
                         input logic [4:0] ff);
        @(posedge ref_clk);
        send_rx <= 1'b1;
        rx_id   <= fid;
        @(posedge ref_clk);
        send_rx <= 1'b0;
        @(posedge ref_clk);
        #1 chk({31'h0, store_req.valid}, {31'h0, hit});
        if (hit) begin
            chk({27'h0, store_req.fifo}, {27'h0, ff});
            chk(store_req.addr, ua(ff, ci_exp[ff]));
            ci_exp[ff] = ci_exp[ff] + 5'h01;
        end
    endtask
    task automatic txd(input logic [4:0] ff);
        @(posedge ref_clk);
        send_tx <= 1'b1;
        tx_fifo <= ff;
        @(posedge ref_clk);
        send_tx <= 1'b0;
        @(posedge ref_clk);
        ci_exp[ff] = ci_exp[ff] + 5'h01;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {resetn, reg_wr, reg_rd, send_rx, send_tx} = 5'h00;
        {reg_addr, reg_wdata, rx_id, tx_fifo} = '0;
        {n_fail, n_checks, cyc} = 0;
        seed = 30;
        base = 32'h0000_4000;
        for (k = 0; k < NUM_FIFO; k++) begin
            ci_exp[k] = 5'h00;
        end
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(OFS_FLTCON1, 32'h0);
        rd(OFS_CONTROL, 32'h1);
        chk({31'h0, config_mode}, 32'h1);
        rd({CI_REGION, 5'h07, 2'h0}, 32'h0);
        rd(10'h3FC, 32'h0);
        wr(OFS_MSG_BASE, 32'h0000_4003);
        for (k = 0; k < NUM_MASK; k++) wr(OFS_MASK0 + 10'(4 * k), 1 << k);
        wr(OFS_FILTER5_ID, 32'h0000_000F);
        wr(OFS_DIRECTION, 32'h8000_0000);
        wr(OFS_CONTROL, 32'h0);
        frame(29'h0, 1'b0, 5'h00);
        for (k = 0; k < NUM_MASK; k++) begin
            set_flt({1'b1, 2'(k), 5'(k + 1)}, 8'h00);
            frame(29'hF ^ (1 << k), 1'b1, 5'(k + 1));
            frame(29'hF, 1'b0, 5'(k + 1));
        end
        wr(OFS_FLTCON1, 32'h0000_259F);
        rd(OFS_FLTCON1, 32'h0000_25E4);
        set_flt(8'h82, 8'hA3);
        frame(29'h3, 1'b1, 5'h03);
        frame(29'h2, 1'b1, 5'h02);
        frame(29'h1, 1'b0, 5'h02);
        rd({CI_REGION, 5'h03, 2'h0}, {27'h0, ci_exp[3]});
        // Receive FIFO 3 is read from its tail, outside configuration
        chk({31'h0, config_mode}, 32'h0);
        rd({UA_REGION, 5'h03, 2'h0}, ua(5'h03, 5'h00));
        wr(OFS_ADVANCE, 32'h3);
        rd({UA_REGION, 5'h03, 2'h0}, ua(5'h03, 5'h01));
        set_flt(8'h9F, 8'h00);
        frame(29'h0, 1'b0, 5'h1F);
        for (k = 0; k < 31; k++) txd(5'h1F);
        rd({CI_REGION, 5'h1F, 2'h0}, 32'h1F);
        txd(5'h1F);
        txd(5'h1F);
        rd({CI_REGION, 5'h1F, 2'h0}, 32'h01);
        rd({UA_REGION, 5'h1F, 2'h0}, ua(5'h1F, 5'h00));
        wr(OFS_ADVANCE, 32'h1F);
        rd({UA_REGION, 5'h1F, 2'h0}, ua(5'h1F, 5'h01));
        for (k = 0; k < 24; k++) begin
            f  = 5'($unsigned($random(seed)) % 31);
            id = 29'($random(seed));
            set_flt({3'b100, f}, 8'h00);
            frame(id, ~id[0], f);
            rd({CI_REGION, f, 2'h0}, {27'h0, ci_exp[f]});
        end
        wr(OFS_CONTROL, 32'h1);
        frame(29'h0, 1'b0, f);
        chk({31'h0, config_mode}, 32'h1);
        rd({CI_REGION, f, 2'h0}, 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
